// ===== logic/cssb_core_status_sfr_bank.sv
`timescale 1ns/1ps
module cssb_core_status_sfr_bank (
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_nrst,
    // Reset causes, power-up is i_nrst
    input  wire logic       i_soft_rst,
    input  wire logic       i_wdt_timeout,
    // Datapath access
    input  wire logic [6:0] i_addr,
    input  wire logic       i_rd,
    input  wire logic       i_we,
    input  wire logic [7:0] i_wdata,
    // Instruction class
    input  wire logic       i_clear_file_instr,
    input  wire logic       i_watchdog_clear_instr,
    input  wire logic       i_sleep_instr,
    // ALU flag results
    input  wire logic       i_flag_we,
    input  wire logic       i_alu_sub,
    input  wire logic       i_alu_zero,
    input  wire logic       i_alu_dcarry,
    input  wire logic       i_alu_carry,
    input  wire logic       i_z_only,
    // Read side
    output logic      [7:0] o_rdata,
    // Status outputs
    output logic      [7:0] o_status,
    output logic            o_bank_select_bit,
    output logic      [7:0] o_indirect_pointer,
    output logic      [7:0] o_pc_low,
    output logic      [7:0] o_pch,
    output logic      [7:0] o_option
);

    // ==========================================================
    // Address decode with bank select.
    // ==========================================================
    logic [7:0] full_addr;
    logic [7:0] st_q;
    logic [7:0] st_d;
    logic [7:0] rd_d;

    assign full_addr = {st_q[cssb_pkg::CSSB_ST_BK], i_addr};

    // Slots: 0 pir 1 cmp 2 opt 3 pclo 4 ptr 5 tra 6 trb 7 pch
    // 8 ictl 9 pie 10 prc 11 eep 12 vref.
    logic [12:0] slot_we;
    logic [7:0]  slot_q [13];
    logic        mir;

    // Locations 0x02-0x04, 0x0A, 0x0B exist in both banks.
    assign mir = (i_addr == 7'h02) || (i_addr == 7'h03) || (i_addr == 7'h04)
              || (i_addr == 7'h0A) || (i_addr == 7'h0B);

    logic [7:0] eff;
    assign eff = mir ? {1'b1, i_addr} : full_addr;

    always_comb begin
        slot_we = '0;
        if (i_we) begin
            case (eff)
                cssb_pkg::CSSB_OFS_PIR:  slot_we[0]  = 1'b1;
                cssb_pkg::CSSB_OFS_CMP:  slot_we[1]  = 1'b1;
                cssb_pkg::CSSB_OFS_OPT:  slot_we[2]  = 1'b1;
                cssb_pkg::CSSB_OFS_PCLO: slot_we[3]  = 1'b1;
                cssb_pkg::CSSB_OFS_PTR:  slot_we[4]  = 1'b1;
                cssb_pkg::CSSB_OFS_TRA:  slot_we[5]  = 1'b1;
                cssb_pkg::CSSB_OFS_TRB:  slot_we[6]  = 1'b1;
                cssb_pkg::CSSB_OFS_PCH:  slot_we[7]  = 1'b1;
                cssb_pkg::CSSB_OFS_ICTL: slot_we[8]  = 1'b1;
                cssb_pkg::CSSB_OFS_PIE:  slot_we[9]  = 1'b1;
                cssb_pkg::CSSB_OFS_PRC:  slot_we[10] = 1'b1;
                cssb_pkg::CSSB_OFS_EEP:  slot_we[11] = 1'b1;
                cssb_pkg::CSSB_OFS_VREF: slot_we[12] = 1'b1;
                default:                 slot_we     = '0;
            endcase
        end
    end

    // ==========================================================
    // Plain registers.
    // ==========================================================
    localparam logic [7:0] RSTV [13] = '{8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h1F, 8'hFF,
                                         8'h00, 8'h00, 8'h00, 8'h00, 8'h07, 8'h00};
    localparam logic [7:0] MSKV [13] = '{8'h40, 8'hCF, 8'hFF, 8'hFF, 8'hFF, 8'h1F, 8'hFF,
                                         8'h1F, 8'hFF, 8'h40, 8'h03, 8'h07, 8'hEF};

    // Pointer and reset-cause bits survive a non-power-up reset, and interrupt
    // control keeps only its lowest bit; clearing them would lose live state.
    localparam logic [12:0] SOFT_KEEP = 13'h0510;
    localparam logic [12:0] SOFT_FILL = 13'h0100;

    genvar g;
    generate
        for (g = 0; g < 13; g++) begin : g_slot
            logic       srst_g;
            logic       fill_g;
            logic       wen_g;
            logic [7:0] wd_g;

            assign srst_g = i_soft_rst && !SOFT_KEEP[g];
            assign fill_g = i_soft_rst && SOFT_FILL[g];
            assign wen_g  = fill_g || (slot_we[g] && !i_soft_rst);
            assign wd_g   = fill_g ? {7'h00, slot_q[g][0]} : i_wdata;
            cssb_reg8 #(
                .RST  (RSTV[g]),
                .MASK (MSKV[g])
            ) u_reg (
                .i_clk      (i_clk),
                .i_nrst     (i_nrst),
                .i_soft_rst (srst_g),
                .i_we       (wen_g),
                .i_wdata    (wd_g),
                .o_q        (slot_q[g])
            );
        end
    endgenerate

    // ==========================================================
    // Status register.
    // ==========================================================
    logic st_hit;
    assign st_hit = i_we && (i_addr == 7'h03);

    always_comb begin
        st_d = st_q;
        if (st_hit) begin
            if (i_clear_file_instr) begin
                st_d[7:5] = 3'h0;
                st_d[cssb_pkg::CSSB_ST_Z] = 1'b1;
            end else begin
                st_d[7:5] = i_wdata[7:5];
                st_d[2:0] = i_wdata[2:0];
            end
        end
        if (i_flag_we && !i_clear_file_instr) begin
            // Flag results win over a data write to status.
            st_d[cssb_pkg::CSSB_ST_Z] = i_alu_zero;
            if (!i_z_only) begin
                st_d[cssb_pkg::CSSB_ST_DCRY] = i_alu_sub ? ~i_alu_dcarry : i_alu_dcarry;
                st_d[cssb_pkg::CSSB_ST_C]  = i_alu_sub ? ~i_alu_carry  : i_alu_carry;
            end
        end
        // Timeout and power-down only move on hardware events.
        if (i_watchdog_clear_instr) begin
            st_d[cssb_pkg::CSSB_ST_TOUT] = 1'b1;
            st_d[cssb_pkg::CSSB_ST_PWDN] = 1'b1;
        end
        if (i_sleep_instr) begin
            st_d[cssb_pkg::CSSB_ST_TOUT] = 1'b1;
            st_d[cssb_pkg::CSSB_ST_PWDN] = 1'b0;
        end
        if (i_wdt_timeout) begin
            st_d[cssb_pkg::CSSB_ST_TOUT] = 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            st_q <= cssb_pkg::CSSB_RST_STAT;
        end else if (i_soft_rst) begin
            st_q <= {3'h0, st_d[4:0]};
        end else begin
            st_q <= st_d;
        end
    end

    // ==========================================================
    // Read path, registered.
    // ==========================================================
    // Reads land in a register so the datapath always sees a settled byte;
    // the price is one cycle of latency on every read.
    always_comb begin
        case (eff)
            cssb_pkg::CSSB_OFS_PIR:  rd_d = slot_q[0];
            cssb_pkg::CSSB_OFS_CMP:  rd_d = slot_q[1];
            cssb_pkg::CSSB_OFS_OPT:  rd_d = slot_q[2];
            cssb_pkg::CSSB_OFS_PCLO: rd_d = slot_q[3];
            cssb_pkg::CSSB_OFS_STAT: rd_d = st_q;
            cssb_pkg::CSSB_OFS_PTR:  rd_d = slot_q[4];
            cssb_pkg::CSSB_OFS_TRA:  rd_d = slot_q[5];
            cssb_pkg::CSSB_OFS_TRB:  rd_d = slot_q[6];
            cssb_pkg::CSSB_OFS_PCH:  rd_d = slot_q[7];
            cssb_pkg::CSSB_OFS_ICTL: rd_d = slot_q[8];
            cssb_pkg::CSSB_OFS_PIE:  rd_d = slot_q[9];
            cssb_pkg::CSSB_OFS_PRC:  rd_d = slot_q[10];
            cssb_pkg::CSSB_OFS_EEP:  rd_d = slot_q[11];
            cssb_pkg::CSSB_OFS_VREF: rd_d = slot_q[12];
            default:                 rd_d = 8'h00;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            o_rdata <= rd_d;
        end
    end

    // The copies lag the internal state by one cycle so every output leaves a flip-flop.
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_status           <= cssb_pkg::CSSB_RST_STAT;
            o_bank_select_bit  <= 1'b0;
            o_indirect_pointer <= 8'h00;
            o_pc_low           <= 8'h00;
            o_pch              <= 8'h00;
            o_option           <= cssb_pkg::CSSB_RST_OPT;
        end else begin
            o_status           <= st_q;
            o_bank_select_bit  <= st_q[cssb_pkg::CSSB_ST_BK];
            o_indirect_pointer <= slot_q[4];
            o_pc_low           <= slot_q[3];
            o_pch              <= slot_q[7];
            o_option           <= slot_q[2];
        end
    end

    // ==========================================================
    // Checks.
    // ==========================================================
    sequence clr_write_s;
        st_hit && i_clear_file_instr && !i_soft_rst;
    endsequence

    clear_file_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        clr_write_s |=> (st_q[7:5] == 3'h0) && st_q[2])
        else $error("clear file status result wrong");

    flag_over_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (i_flag_we && !i_clear_file_instr && !i_soft_rst) |=> st_q[2] == $past(i_alu_zero))
        else $error("zero flag not from alu");

    sub_borrow_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (i_flag_we && !i_z_only && !i_clear_file_instr && i_alu_sub && !i_soft_rst)
        |=> st_q[0] == !$past(i_alu_carry))
        else $error("borrow polarity wrong");

    flag_hold_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (!i_watchdog_clear_instr && !i_sleep_instr && !i_wdt_timeout)
        |=> $stable(st_q[4:3]))
        else $error("timeout or power-down moved");

    wdt_to_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        i_wdt_timeout |=> !st_q[4])
        else $error("timeout flag not cleared");

    sleep_flags_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (i_sleep_instr && !i_wdt_timeout) |=> !st_q[3] && st_q[4])
        else $error("sleep flags wrong");

    soft_rst_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        i_soft_rst |=> (st_q[7:5] == 3'h0) && (slot_q[2] == 8'hFF))
        else $error("soft reset values wrong");

    unimpl_rd_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (i_rd && ((i_addr == 7'h0D) || (eff == 8'h87))) |=> o_rdata == 8'h00)
        else $error("unimplemented read not zero");

    plain_wr_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (st_hit && !i_clear_file_instr && !i_flag_we && !i_soft_rst)
        |=> st_q[7:5] == $past(i_wdata[7:5]))
        else $error("status write lost");

    // A bank-one write to location 0x0C must reach the enables and leave the flags alone.
    sequence bank1_enable_wr_s;
        i_we && !i_soft_rst && (i_addr == 7'h0C) && st_q[cssb_pkg::CSSB_ST_BK];
    endsequence

    bank_pick_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        bank1_enable_wr_s |=> (slot_q[9] == ($past(i_wdata) & 8'h40)) && $stable(slot_q[0]))
        else $error("bank select picked wrong register");

    sequence ptr_wr_s;
        i_we && !i_soft_rst && (i_addr == 7'h04);
    endsequence

    mirror_ptr_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        ptr_wr_s |=> slot_q[4] == $past(i_wdata))
        else $error("mirrored pointer write lost");

    sequence soft_only_s;
        i_soft_rst && !i_we;
    endsequence

    soft_keep_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        soft_only_s |=> (slot_q[4] == $past(slot_q[4])) && (slot_q[8][7:1] == 7'h00))
        else $error("soft reset lost kept contents");

endmodule

// ===== logic/cssb_pkg.sv
package cssb_pkg;

    // ==========================================================
    // Register offsets, bit 7 is the bank, low seven bits are the location.
    // ==========================================================
    localparam logic [7:0] CSSB_OFS_PIR   = 8'h0C;
    localparam logic [7:0] CSSB_OFS_CMP   = 8'h1F;
    localparam logic [7:0] CSSB_OFS_IND   = 8'h80;
    localparam logic [7:0] CSSB_OFS_OPT   = 8'h81;
    localparam logic [7:0] CSSB_OFS_PCLO  = 8'h82;
    localparam logic [7:0] CSSB_OFS_STAT  = 8'h83;
    localparam logic [7:0] CSSB_OFS_PTR   = 8'h84;
    localparam logic [7:0] CSSB_OFS_TRA   = 8'h85;
    localparam logic [7:0] CSSB_OFS_TRB   = 8'h86;
    localparam logic [7:0] CSSB_OFS_PCH   = 8'h8A;
    localparam logic [7:0] CSSB_OFS_ICTL  = 8'h8B;
    localparam logic [7:0] CSSB_OFS_PIE   = 8'h8C;
    localparam logic [7:0] CSSB_OFS_PRC   = 8'h8E;
    localparam logic [7:0] CSSB_OFS_EEP   = 8'h90;
    localparam logic [7:0] CSSB_OFS_VREF  = 8'h9F;

    // ==========================================================
    // Status bit positions.
    // ==========================================================
    localparam int CSSB_ST_C   = 0;
    localparam int CSSB_ST_DCRY = 1;
    localparam int CSSB_ST_Z    = 2;
    localparam int CSSB_ST_PWDN = 3;
    localparam int CSSB_ST_TOUT = 4;
    localparam int CSSB_ST_BK  = 5;

    // ==========================================================
    // Implemented bit masks.
    // ==========================================================
    localparam logic [7:0] CSSB_MSK_PIR  = 8'h40;
    localparam logic [7:0] CSSB_MSK_CMP  = 8'hCF;
    localparam logic [7:0] CSSB_MSK_TRA  = 8'h1F;
    localparam logic [7:0] CSSB_MSK_PCH  = 8'h1F;
    localparam logic [7:0] CSSB_MSK_PRC  = 8'h03;
    localparam logic [7:0] CSSB_MSK_EEP  = 8'h07;
    localparam logic [7:0] CSSB_MSK_VREF = 8'hEF;

    // ==========================================================
    // Reset values.
    // ==========================================================
    localparam logic [7:0] CSSB_RST_ZERO = 8'h00;
    localparam logic [7:0] CSSB_RST_OPT  = 8'hFF;
    localparam logic [7:0] CSSB_RST_TRA  = 8'h1F;
    localparam logic [7:0] CSSB_RST_TRB  = 8'hFF;
    localparam logic [7:0] CSSB_RST_EEP  = 8'h07;
    localparam logic [7:0] CSSB_RST_STAT = 8'h18;

    // ==========================================================
    // Unused slot count; the bank builds 13 plain register slots plus status.
    // ==========================================================
    localparam int CSSB_NSLOT = 16;

endpackage

// ===== logic/cssb_reg8.sv
`timescale 1ns/1ps
module cssb_reg8 #(
    parameter logic [7:0] RST  = 8'h00,
    parameter logic [7:0] MASK = 8'hFF
) (
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_nrst,
    // Reset kind
    input  wire logic       i_soft_rst,
    // Write side
    input  wire logic       i_we,
    input  wire logic [7:0] i_wdata,
    // Stored value
    output logic      [7:0] o_q
);

    // ==========================================================
    // One masked register; unimplemented bits stay zero.
    // ==========================================================
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_q <= RST & MASK;
        end else if (i_soft_rst) begin
            o_q <= RST & MASK;
        end else if (i_we) begin
            o_q <= i_wdata & MASK;
        end
    end

endmodule

// ===== test/core_status_sfr_bank_tb_top.sv
`timescale 1ns/1ps
// ==========================================================
// Bench top.
// ==========================================================
module core_status_sfr_bank_tb_top;
    logic       clk;
    logic       nrst;
    logic       srst, wdt, wclr, slp, rd, we, cf, fwe, sub, az, adc, ac, zo;
    logic [6:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [7:0] status;
    logic       bank;
    logic [7:0] iptr, pc_lo, pch, opt;
    int         failures;
    int         num_checks;
    int         cycles;

    cssb_cpu_model u_cssb_cpu_model (.i_clk(clk), .o_soft_rst(srst), .o_wdt_timeout(wdt),
        .o_watchdog_clear_instr(wclr), .o_sleep_instr(slp), .o_addr(addr), .o_rd(rd), .o_we(we),
        .o_wdata(wdata), .o_clear_file_instr(cf), .o_flag_we(fwe), .o_alu_sub(sub), .o_alu_zero(az),
        .o_alu_dcarry(adc), .o_alu_carry(ac), .o_z_only(zo));

    cssb_core_status_sfr_bank u_cssb_core_status_sfr_bank (.i_clk(clk), .i_nrst(nrst), .i_soft_rst(srst),
        .i_wdt_timeout(wdt), .i_addr(addr), .i_rd(rd), .i_we(we), .i_wdata(wdata), .i_clear_file_instr(cf),
        .i_watchdog_clear_instr(wclr), .i_sleep_instr(slp), .i_flag_we(fwe), .i_alu_sub(sub),
        .i_alu_zero(az), .i_alu_dcarry(adc), .i_alu_carry(ac), .i_z_only(zo), .o_rdata(rdata),
        .o_status(status), .o_bank_select_bit(bank), .o_indirect_pointer(iptr), .o_pc_low(pc_lo),
        .o_pch(pch), .o_option(opt));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ==========================================================
    // Shared checks and accesses.
    // ==========================================================
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rdc(input logic [6:0] a, input logic [7:0] exp);
        u_cssb_cpu_model.cyc(a, 8'h00, 2'b10, 7'h00);
        chk(rdata, exp);
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d, input logic [6:0] f);
        u_cssb_cpu_model.cyc(a, d, 2'b01, f);
    endtask

    task automatic end_of_test;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ==========================================================
    // Scenarios.
    // ==========================================================
    task automatic t_reset_map;
        logic [6:0] a [0:9] = '{7'h01, 7'h05, 7'h06, 7'h0A, 7'h10, 7'h1F, 7'h0C, 7'h02, 7'h0D, 7'h00};
        logic [7:0] e [0:9] = '{8'hFF, 8'h1F, 8'hFF, 8'h00, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        rdc(7'h03, 8'h18);
        wr(7'h03, 8'h20, 7'h00);
        rdc(7'h03, 8'h38);
        for (int i = 0; i < 10; i++) begin
            rdc(a[i], e[i]);
        end
    endtask

    task automatic t_flags;
        wr(7'h03, 8'h27, 7'h00);
        rdc(7'h03, 8'h3F);
        wr(7'h03, 8'h27, 7'h22);
        rdc(7'h03, 8'h39);
        wr(7'h0A, 8'h15, 7'h34);
        rdc(7'h0A, 8'h15);
        chk(pch, 8'h15);
        rdc(7'h03, 8'h39);
        wr(7'h06, 8'h00, 7'h29);
        rdc(7'h03, 8'h3D);
    endtask

    task automatic t_clear_events;
        wr(7'h03, 8'h23, 7'h00);
        wr(7'h03, 8'h00, 7'h40);
        rdc(7'h03, 8'h1F);
        chk({7'h00, bank}, 8'h00);
        u_cssb_cpu_model.ev(4'h4);
        wr(7'h03, 8'h1F, 7'h00);
        rdc(7'h03, 8'h0F);
        u_cssb_cpu_model.ev(4'h1);
        rdc(7'h03, 8'h17);
        u_cssb_cpu_model.ev(4'h2);
        rdc(7'h03, 8'h1F);
    endtask

    task automatic t_mirror;
        wr(7'h04, 8'hA5, 7'h00);
        wr(7'h02, 8'h5A, 7'h00);
        wr(7'h0C, 8'hFF, 7'h00);
        wr(7'h03, 8'h20, 7'h00);
        rdc(7'h04, 8'hA5);
        chk(iptr, 8'hA5);
        rdc(7'h02, 8'h5A);
        chk(pc_lo, 8'h5A);
        rdc(7'h0C, 8'h00);
        wr(7'h0C, 8'h00, 7'h00);
        wr(7'h05, 8'hFF, 7'h00);
        rdc(7'h05, 8'h1F);
        wr(7'h0D, 8'hFF, 7'h00);
        rdc(7'h0D, 8'h00);
        wr(7'h03, 8'h00, 7'h00);
        rdc(7'h0C, 8'h40);
    endtask

    task automatic t_resets;
        wr(7'h03, 8'h20, 7'h00);
        wr(7'h01, 8'h55, 7'h00);
        rdc(7'h01, 8'h55);
        chk(opt, 8'h55);
        wr(7'h0B, 8'hFF, 7'h00);
        u_cssb_cpu_model.ev(4'h4);
        u_cssb_cpu_model.ev(4'h8);
        rdc(7'h03, 8'h08);
        rdc(7'h0B, 8'h01);
        chk(iptr, 8'hA5);
        wr(7'h03, 8'h20, 7'h00);
        rdc(7'h01, 8'hFF);
        chk(opt, 8'hFF);
        @(posedge clk);
        #1;
        nrst = 1'b0;
        @(posedge clk);
        #1;
        nrst = 1'b1;
        chk(status, 8'h18);
        chk(iptr, 8'h00);
        rdc(7'h03, 8'h18);
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            failures++;
            $display("Error at %0t: run did not finish", $time);
            end_of_test();
        end
    end

    initial begin
        failures = 0;
        num_checks = 0;
        cycles = 0;
        nrst = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        nrst = 1'b1;
        t_reset_map();
        t_flags();
        t_clear_events();
        t_mirror();
        t_resets();
        end_of_test();
    end
endmodule

// ===== test/cssb_cpu_model.sv
`timescale 1ns/1ps
// ==========================================================
// Instruction datapath model, changes its outputs 1 ns after the rising edges its tasks wait on.
// ==========================================================
module cssb_cpu_model (
    // Clock
    input  wire logic       i_clk,
    // Reset causes and events
    output logic            o_soft_rst,
    output logic            o_wdt_timeout,
    output logic            o_watchdog_clear_instr,
    output logic            o_sleep_instr,
    // Register access
    output logic      [6:0] o_addr,
    output logic            o_rd,
    output logic            o_we,
    output logic      [7:0] o_wdata,
    // Instruction class and flag results
    output logic            o_clear_file_instr,
    output logic            o_flag_we,
    output logic            o_alu_sub,
    output logic            o_alu_zero,
    output logic            o_alu_dcarry,
    output logic            o_alu_carry,
    output logic            o_z_only
);
    initial begin
        {o_soft_rst, o_wdt_timeout, o_watchdog_clear_instr, o_sleep_instr} = 4'h0;
        {o_rd, o_we, o_addr, o_wdata} = 17'h00000;
        {o_clear_file_instr, o_flag_we, o_alu_sub, o_alu_zero, o_alu_dcarry, o_alu_carry, o_z_only} = 7'h00;
    end

    // One access; f is {clear_file, flag_we, sub, zero, dcarry, carry, z_only}.
    // Released address and data lines show the inverse, so a stale value is never mistaken for a hold.
    task automatic cyc(input logic [6:0] a, input logic [7:0] d, input logic [1:0] rw, input logic [6:0] f);
        @(posedge i_clk);
        #1;
        o_addr = a;
        o_wdata = (a == 7'h03) ? {2'b00, d[5:0]} : d;
        {o_rd, o_we} = rw;
        {o_clear_file_instr, o_flag_we, o_alu_sub, o_alu_zero, o_alu_dcarry, o_alu_carry, o_z_only} = f;
        @(posedge i_clk);
        #1;
        o_addr = ~o_addr;
        o_wdata = ~o_wdata;
        {o_rd, o_we} = 2'b00;
        {o_clear_file_instr, o_flag_we, o_alu_sub, o_alu_zero, o_alu_dcarry, o_alu_carry, o_z_only} = 7'h00;
    endtask

    // One-cycle event pulse; e is {soft_rst, wdt_timeout, watchdog_clear, sleep}.
    task automatic ev(input logic [3:0] e);
        @(posedge i_clk);
        #1;
        {o_soft_rst, o_wdt_timeout, o_watchdog_clear_instr, o_sleep_instr} = e;
        @(posedge i_clk);
        #1;
        {o_soft_rst, o_wdt_timeout, o_watchdog_clear_instr, o_sleep_instr} = 4'h0;
    endtask
endmodule
